// file: rtl/ddrrp_read_port.sv
// Read port of a synchronous burst SRAM with a double-data-rate output bus.
// Assumes K, K-bar, select, address and PLL-disable arrive asynchronously and
// are oversampled by sys_clk; the array is preloaded through a sys_clk port.
`timescale 1ns/10ps
`default_nettype none
module ddrrp_read_port #(
  parameter bit WideCfg = 1'b0
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      kClk,
  input  wire logic                      kClkN,
  input  wire logic                      readPortSelectN,
  input  wire logic                      pllDisableN,
  input  wire ddrrp_pkg::ddrrp_addr_t    addrPin,
  output logic [(WideCfg ? ddrrp_pkg::Q_W_WIDE : ddrrp_pkg::Q_W_NARROW)-1:0] readData,
  output logic                           readDataOeN,
  output logic                           outputValid,
  output logic                           echoTrue,
  output logic                           echoInverse,
  input  wire logic                      memWrEn,
  input  wire ddrrp_pkg::ddrrp_addr_t    memWrAddr,
  input  wire logic [ddrrp_pkg::WIDX_W-1:0] memWrWord,
  input  wire logic [(WideCfg ? ddrrp_pkg::Q_W_WIDE : ddrrp_pkg::Q_W_NARROW)-1:0] memWrData
);
  import ddrrp_pkg::*;

  localparam int QW = WideCfg ? Q_W_WIDE : Q_W_NARROW;

  ddrrp_pin_if pins ();

  // Storage for the modelled array, four words per address.
  logic [QW-1:0]      memArray [MEM_WORDS];

  // Request pipeline, one stage per link half-cycle.
  logic               reqValid_q [PIPE_DEPTH];
  ddrrp_addr_t        reqAddr_q  [PIPE_DEPTH];
  logic               lastAccepted_q;

  // Burst and output state.
  ddrrp_drv_t         drvState_q;
  ddrrp_drv_t         drvState_d;
  logic [WIDX_W-1:0]  burstCnt_q;
  ddrrp_addr_t        burstAddr_q;
  logic [QW-1:0]      readData_q;
  logic               readDataOeN_q;
  logic               outputValid_q;
  logic               echoTrue_q;
  logic               echoInverse_q;

  // Decoded per-edge controls.
  logic               anyEdge;
  logic               accept;
  logic               startTap;
  ddrrp_addr_t        tapAddr;
  logic               inBurst;
  logic               wordNow;
  logic [WIDX_W-1:0]  wordIdx;
  ddrrp_addr_t        wordAddr;
  logic [QW-1:0]      wordData;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and edge detection.
  ddrrp_pin_sync u_pin_sync (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .kClk            (kClk),
    .kClkN           (kClkN),
    .readPortSelectN (readPortSelectN),
    .pllDisableN     (pllDisableN),
    .addrPin         (addrPin),
    .pins            (pins.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Array load port on sys_clk; no reset so it maps onto plain memory.
  always_ff @(posedge sys_clk) begin
    if (memWrEn) begin
      memArray[mem_index(memWrAddr, memWrWord)] <= memWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request acceptance. A read is taken only on a K rise with select low,
  // and never on the rise straight after an accepted one, because the
  // previous burst still owns the next two half-cycles of the bus.
  assign anyEdge = pins.kRise | pins.kNRise;
  assign accept  = pins.kRise & pins.selActive & ~lastAccepted_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lastAccepted_q <= 1'b0;
    end else if (pins.kRise) begin
      lastAccepted_q <= accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latency pipeline: the request and its registered address shift one
  // stage on every half-cycle edge through all PIPE_DEPTH stages, whatever the mode.
  genvar p;
  generate
    for (p = 0; p < PIPE_DEPTH; p++) begin : g_pipe
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          reqValid_q[p] <= 1'b0;
          reqAddr_q[p]  <= '0;
        end else if (anyEdge) begin
          if (p == 0) begin
            reqValid_q[p] <= accept;
            reqAddr_q[p]  <= pins.addr;
          end else begin
            reqValid_q[p] <= reqValid_q[(p == 0) ? 0 : p - 1];
            reqAddr_q[p]  <= reqAddr_q[(p == 0) ? 0 : p - 1];
          end
        end
      end
    end
  endgenerate

  // Tap selection by PLL mode; the edge that reads the tap is the launch edge.
  assign startTap = anyEdge & (pins.pllOn ? reqValid_q[LAT_HALF_PLL_ON-1]
                                          : reqValid_q[LAT_HALF_PLL_OFF-1]);
  assign tapAddr  = pins.pllOn ? reqAddr_q[LAT_HALF_PLL_ON-1] : reqAddr_q[LAT_HALF_PLL_OFF-1];

  ////////////////////////////////////////////////////////////////////////////
  // Word selection: a new burst starts at word zero and walks upward; a
  // running burst supplies the next word on every rise of K or K-bar.
  assign inBurst  = (drvState_q == DRV_BURST);
  assign wordNow  = startTap | (anyEdge & inBurst);
  assign wordIdx  = startTap ? FIRST_WORD : burstCnt_q;
  assign wordAddr = startTap ? tapAddr : burstAddr_q;
  assign wordData = memArray[mem_index(wordAddr, wordIdx)];

  // Next driver state.
  always_comb begin
    drvState_d = drvState_q;
    if (wordNow) begin
      drvState_d = (wordIdx == LAST_WORD) ? DRV_HOLD : DRV_BURST;
    end else if (pins.kNRise) begin
      drvState_d = DRV_OFF;
    end else begin
      unique case (drvState_q)
        DRV_OFF:   drvState_d = DRV_OFF;
        DRV_BURST: drvState_d = DRV_BURST;
        DRV_HOLD:  drvState_d = DRV_HOLD;
        default:   drvState_d = DRV_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst counter and address.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drvState_q  <= DRV_OFF;
      burstCnt_q  <= FIRST_WORD;
      burstAddr_q <= '0;
    end else begin
      drvState_q <= drvState_d;
      if (wordNow) begin
        burstCnt_q  <= wordIdx + 2'h1;
        burstAddr_q <= wordAddr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output register. The last word stays on the bus until the next K-bar rise,
  // one half-cycle with the PLL on and two with it off, and is released only there, so a neighbour device
  // in a depth-expanded bank can take over without a gap or a clash.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      readData_q    <= '0;
      readDataOeN_q <= 1'b1;
      outputValid_q <= 1'b0;
    end else if (anyEdge) begin
      outputValid_q <= wordNow;
      if (wordNow) begin
        readData_q    <= wordData;
        readDataOeN_q <= 1'b0;
      end else if (pins.kNRise) begin
        readDataOeN_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Echo clocks follow the sampled K and K-bar levels on the same sys_clk
  // edge that updates data and valid, which keeps them edge aligned.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      echoTrue_q    <= 1'b0;
      echoInverse_q <= 1'b1;
    end else begin
      echoTrue_q    <= pins.kLevel;
      echoInverse_q <= pins.kNLevel;
    end
  end

  // Outputs come straight from flip-flops.
  assign readData    = readData_q;
  assign readDataOeN = readDataOeN_q;
  assign outputValid = outputValid_q;
  assign echoTrue    = echoTrue_q;
  assign echoInverse = echoInverse_q;
endmodule
`default_nettype wire

// file: rtl/ddrrp_pkg.sv
// Shared constants and types for the double-data-rate SRAM read port.
// Assumes a single system clock that oversamples the link clocks.
package ddrrp_pkg;

  // Read data widths for the narrow and the wide configuration.
  localparam int Q_W_NARROW = 18;
  localparam int Q_W_WIDE   = 36;

  // Read address register width and the size of the modelled array.
  localparam int ADDR_W   = 18;
  localparam int ARRAY_AW = 6;
  localparam int WIDX_W   = 2;
  localparam int MEM_IDX_W = ARRAY_AW + WIDX_W;
  localparam int MEM_WORDS = 1 << MEM_IDX_W;

  // Burst of four words; the last word index ends a burst.
  localparam int           BURST_LEN  = 4;
  localparam logic [1:0]   FIRST_WORD = 2'h0;
  localparam logic [1:0]   LAST_WORD  = 2'h3;

  // Read latency counted in link half-cycles (K and K-bar rises).
  // With the PLL on, 2.5 cycles; with it off, one cycle.
  localparam int LAT_HALF_PLL_ON  = 5;
  localparam int LAT_HALF_PLL_OFF = 2;
  localparam int PIPE_DEPTH       = LAT_HALF_PLL_ON;

  // Pin synchroniser depth.
  localparam int SYNC_STAGES = 2;

  // Output driver state.
  typedef enum logic [1:0] {
    DRV_OFF   = 2'b00,
    DRV_BURST = 2'b01,
    DRV_HOLD  = 2'b10
  } ddrrp_drv_t;

  typedef logic [ADDR_W-1:0] ddrrp_addr_t;

  // Array index of one word of a burst, used by both read and load paths.
  function automatic logic [MEM_IDX_W-1:0] mem_index(ddrrp_addr_t addr, logic [WIDX_W-1:0] widx);
    mem_index = {addr[ARRAY_AW-1:0], widx};
  endfunction

endpackage

// file: rtl/ddrrp_pin_if.sv
// Bundle of synchronised link events passed from the pin sampler to the read port.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
`default_nettype none
interface ddrrp_pin_if;
  import ddrrp_pkg::*;

  logic        kRise;
  logic        kNRise;
  logic        kLevel;
  logic        kNLevel;
  logic        selActive;
  logic        pllOn;
  ddrrp_addr_t addr;

  modport src (output kRise, output kNRise, output kLevel, output kNLevel,
               output selActive, output pllOn, output addr);
  modport snk (input kRise, input kNRise, input kLevel, input kNLevel,
               input selActive, input pllOn, input addr);
endinterface
`default_nettype wire

// file: rtl/ddrrp_pin_sync.sv
// Pin sampler: two-flop synchronisers for every link pin and edge detection
// of both input clocks. Assumes the link pins are asynchronous to sys_clk and
// that the address and select are stable for several sys_clk cycles around K.
`timescale 1ns/10ps
`default_nettype none
module ddrrp_pin_sync (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 kClk,
  input  wire logic                 kClkN,
  input  wire logic                 readPortSelectN,
  input  wire logic                 pllDisableN,
  input  wire ddrrp_pkg::ddrrp_addr_t addrPin,
  ddrrp_pin_if.src                  pins
);
  import ddrrp_pkg::*;

  localparam int RAW_W = ADDR_W + 4;

  logic [RAW_W-1:0] rawPins;
  logic [RAW_W-1:0] stage_q [SYNC_STAGES];
  logic [RAW_W-1:0] syncPins;
  logic             kPrev_q;
  logic             kNPrev_q;

  assign rawPins = {pllDisableN, readPortSelectN, kClkN, kClk, addrPin};

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser chain; the first stage feeds only the second.
  // Reset to all ones so no false clock edge or select is seen on release.
  genvar s;
  generate
    for (s = 0; s < SYNC_STAGES; s++) begin : g_stage
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          stage_q[s] <= '1;
        end else begin
          stage_q[s] <= (s == 0) ? rawPins : stage_q[(s == 0) ? 0 : s - 1];
        end
      end
    end
  endgenerate

  assign syncPins = stage_q[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // Previous clock levels for edge detection.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      kPrev_q  <= 1'b1;
      kNPrev_q <= 1'b1;
    end else begin
      kPrev_q  <= syncPins[ADDR_W];
      kNPrev_q <= syncPins[ADDR_W+1];
    end
  end

  // Decoded events and levels handed to the read port.
  assign pins.kLevel    = syncPins[ADDR_W];
  assign pins.kNLevel   = syncPins[ADDR_W+1];
  assign pins.kRise     = syncPins[ADDR_W] & ~kPrev_q;
  assign pins.kNRise    = syncPins[ADDR_W+1] & ~kNPrev_q;
  assign pins.selActive = ~syncPins[ADDR_W+2];
  assign pins.pllOn     = syncPins[ADDR_W+3];
  assign pins.addr      = syncPins[ADDR_W-1:0];
endmodule
`default_nettype wire

// file: tb/ddrrp_props.sv
// Checker for the read port, watching only the top-level pins.
// Assumes the bench holds select and address for a whole K cycle.
`timescale 1ns/10ps
`default_nettype none
module ddrrp_props #(
  parameter bit WideCfg = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic readPortSelectN,
  input wire logic pllDisableN,
  input wire logic [(WideCfg ? ddrrp_pkg::Q_W_WIDE : ddrrp_pkg::Q_W_NARROW)-1:0] readData,
  input wire logic readDataOeN,
  input wire logic outputValid,
  input wire logic echoTrue
);
  import ddrrp_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic       echoPrev_q;
  logic [7:0] wordCnt_q;
  wire        echoEdge = echoTrue ^ echoPrev_q;
  //////////////////////////////////////////////////////////////////////////////
  // Count echo edges while valid, so a burst that ends early is caught.
  always_ff @(posedge sys_clk) begin
    echoPrev_q <= echoTrue;
    if (!rst_n || !outputValid) begin
      wordCnt_q <= 8'h00;
    end else if (echoEdge) begin
      wordCnt_q <= wordCnt_q + 8'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  data_stable_a: assert property (outputValid && $past(outputValid) && !echoEdge |-> $stable(readData))
    else $error("read data moved inside a half-cycle");
  valid_align_a: assert property ($changed(outputValid) |-> echoEdge)
    else $error("valid changed away from an echo edge");
  burst_four_a: assert property ($fell(outputValid) |-> wordCnt_q != 8'h00 && wordCnt_q[1:0] == 2'b00)
    else $error("burst was not a multiple of four words");
  echo_run_a: assert property (1'b1 |-> ##[1:8] echoEdge)
    else $error("echo clock stopped");
  lat_pll_a: assert property ($rose(outputValid) && pllDisableN |-> $past(readPortSelectN, 22) == 1'b0)
    else $error("burst start not tied to a request");
  lat_legacy_a: assert property ($rose(outputValid) && !pllDisableN |-> $past(readPortSelectN, 10) == 1'b0)
    else $error("legacy burst start not tied to a request");
  tri_after_a: assert property ($fell(outputValid) |-> ##[0:5] readDataOeN)
    else $error("outputs not tristated after the burst");
  valid_driven_a: assert property (outputValid |-> !readDataOeN)
    else $error("valid while outputs tristated");
  drive_start_a: assert property ($fell(readDataOeN) |-> outputValid)
    else $error("outputs driven without valid data");
endmodule
bind ddrrp_read_port ddrrp_props #(.WideCfg(WideCfg)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .readPortSelectN(readPortSelectN), .pllDisableN(pllDisableN),
  .readData(readData), .readDataOeN(readDataOeN), .outputValid(outputValid), .echoTrue(echoTrue));
`default_nettype wire

// file: tb/ddrrp_host_model.sv
// Host controller model: makes K and K-bar and captures burst words.
// Assumes the narrow configuration and the 50 MHz system clock.
`timescale 1ns/10ps
`default_nettype none
module ddrrp_host_model (
  input  wire logic        sys_clk,
  output logic             kClk,
  output logic             kClkN,
  input  wire logic [17:0] readData,
  input  wire logic        readDataOeN,
  input  wire logic        outputValid,
  input  wire logic        echoTrue,
  output logic             capValid,
  output logic [17:0]      capData
);
  logic echoPrev_q;
  // Free-running 160 ns clocks, well under the legacy-mode ceiling; odd offset keeps phase apart.
  initial begin
    kClk = 1'b0;
    kClkN = 1'b1;
    #7;
    forever begin
      #80 kClk = ~kClk;
      kClkN = ~kClkN;
    end
  end
  // Capture one word per echo edge, qualified by valid rather than a cycle count.
  always_ff @(posedge sys_clk) begin
    echoPrev_q <= echoTrue;
    capValid <= outputValid && !readDataOeN && (echoTrue != echoPrev_q);
    capData <= readData;
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Testbench: random read traffic in both latency modes against a queue model.
// Assumes the host model supplies the link clocks.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ddrrp_pkg::*;
  logic        sys_clk, rst_n, kClk, kClkN, readPortSelectN, pllDisableN, memWrEn;
  ddrrp_addr_t addrPin, memWrAddr;
  logic [1:0]  memWrWord;
  logic [17:0] memWrData, readData, capData, expWord;
  logic [35:0] readDataWide;
  logic        readDataOeN, outputValid, echoTrue, echoInverse, capValid;
  logic [17:0] mem [256];
  logic [17:0] expQ [$];
  logic [15:0] rnd;
  bit          prevAcc;
  int          n_errors, checks, i, m;
  // Narrow configuration under test.
  ddrrp_read_port #(.WideCfg(1'b0)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .kClk(kClk), .kClkN(kClkN), .readPortSelectN(readPortSelectN),
    .pllDisableN(pllDisableN), .addrPin(addrPin), .readData(readData), .readDataOeN(readDataOeN),
    .outputValid(outputValid), .echoTrue(echoTrue), .echoInverse(echoInverse), .memWrEn(memWrEn),
    .memWrAddr(memWrAddr), .memWrWord(memWrWord), .memWrData(memWrData));
  ddrrp_host_model u_host (.sys_clk(sys_clk), .kClk(kClk), .kClkN(kClkN), .readData(readData),
    .readDataOeN(readDataOeN), .outputValid(outputValid), .echoTrue(echoTrue), .capValid(capValid),
    .capData(capData));
  // Wide configuration on the same pins; its upper half is loaded with the inverse of the lower.
  ddrrp_read_port #(.WideCfg(1'b1)) u_dutWide (
    .sys_clk(sys_clk), .rst_n(rst_n), .kClk(kClk), .kClkN(kClkN), .readPortSelectN(readPortSelectN),
    .pllDisableN(pllDisableN), .addrPin(addrPin), .readData(readDataWide), .readDataOeN(),
    .outputValid(), .echoTrue(), .echoInverse(), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
    .memWrWord(memWrWord), .memWrData({~memWrData, memWrData}));
  //////////////////////////////////////////////////////////////////////////////
  // System clock, 20 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One K cycle: change select and address just after K falls, so they settle before the rise.
  task automatic slot(input bit req, input ddrrp_addr_t a);
    int w;
    while (kClk !== 1'b1) @(posedge sys_clk);
    while (kClk !== 1'b0) @(posedge sys_clk);
    readPortSelectN <= !req;
    addrPin <= a;
    if (req && !prevAcc) begin
      for (w = 0; w < 4; w++) expQ.push_back(mem[{a[5:0], w[1:0]}]);
    end
    prevAcc = req && !prevAcc;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Every captured word must be the next one the model expects.
  always @(posedge sys_clk) begin
    if (capValid === 1'b1) begin
      if (expQ.size() == 0) begin
        check(36'h1, 36'h0);
      end else begin
        expWord = expQ.pop_front();
        check(36'(capData), 36'(expWord));
        check(readDataWide, {~expWord, expWord});
      end
      check(36'(echoInverse ^ echoTrue), 36'h1);
    end
  end
  // Main sequence: reset, preload, then random bursts with the PLL on and off.
  initial begin
    rst_n = 1'b0;
    readPortSelectN = 1'b1;
    pllDisableN = 1'b1;
    addrPin = '0;
    memWrEn = 1'b0;
    memWrAddr = '0;
    memWrWord = 2'b00;
    memWrData = '0;
    rnd = 16'h4746;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 check(36'({readDataOeN, outputValid}), 36'h2);
    for (i = 0; i < 256; i++) begin
      @(posedge sys_clk);
      rnd = lfsr(rnd);
      mem[i] = {rnd[15:14], rnd};
      memWrEn <= 1'b1;
      memWrAddr <= {rnd[11:0], i[7:2]};
      memWrWord <= i[1:0];
      memWrData <= {rnd[15:14], rnd};
    end
    @(posedge sys_clk);
    memWrEn <= 1'b0;
    for (m = 0; m < 2; m++) begin
      pllDisableN <= (m == 0);
      for (i = 0; i < 40; i++) begin
        rnd = lfsr(rnd);
        slot(i < 3 || rnd[0], {rnd[15:4], rnd[5:0]});
      end
      repeat (6) slot(1'b0, '0);
      check(36'(expQ.size()), 36'h0);
      check(36'({readDataOeN, outputValid}), 36'h2);
    end
    results();
  end
  // Watchdog: the run needs about 20 us.
  initial begin
    #100000;
    n_errors++;
    $display("[ERR] %0t ns: run timed out", $time);
    results();
  end
endmodule
`default_nettype wire
